// *** design/cantmc_dev.sv ***
`default_nettype none
`include "cantmc_regs.svh"
// Summary of operation
// (RQ1) Power-up in off mode, bus halted.
// (RQ2) Off mode selectable in every power mode.
// (RQ3) Off mode ignores bus wake activity.
// (RQ4) Host enables normal mode in normal power.
// (RQ5) Normal mode only in normal/stop power.
// (RQ6) Controller holds transmit recessive during enabling.
// (RQ7) Early dominant must return recessive until enabled.
// (RQ8) Early dominant blocked; next dominant transmitted.
// (RQ9) Normal mode: bus follows transmit input.
// (RQ10) Receiver level shown on receive output.
// (RQ11) Paths carry up to 2 Mbaud.
// (RQ12) Receive-only: driver off, receive continues.
// (RQ13) Receive-only accepted only in normal/stop.
// (RQ14) Wake-capable mode detects bus wake-up.
// (RQ15) Host writes mode bits; device applies them.
// (RQ16) Wake-capable code 01, kept after wake.
// (RQ17) After wake, receive held low until mode change.
// (RQ18) Dominant timeout: driver off, receive-only, fail flag.
// (RQ19) Leaving normal/stop power drops normal and receive-only.
// (RQ20) Enabling delay counted; driving blocked until done.
module cantmc_dev
  import cantmc_pkg::*;
#(
  parameter int EN_CYC = `CANTMC_EN_DELAY_CYC,
  parameter int TXD_TO_CYC = `CANTMC_TXD_TO_CYC,
  parameter int WAKE_CYC = `CANTMC_WAKE_FILT_CYC,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic mclk, // Clock.
  input wire logic reset, // Synchronous reset.
  cantmc_if.dev link, // Host and controller side.
  input wire logic bus_rx_dom, // Differential receiver, high when dominant.
  output logic bus_drive_dom, // Output stages driving dominant.
  output logic bus_drv_en, // Driver stage enabled.
  output logic bus_bias_en // Bus biased for normal or receive-only.
);
  cantmc_state_t st_r, st_nxt;
  logic [1:0] mode_r, mode_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic [31:0] dom_r, dom_nxt;
  logic [15:0] wk_r, wk_nxt;
  logic armed_r, armed_nxt;
  logic woke_r, woke_nxt;
  logic fail_r, fail_nxt;
  logic wait_rec_r, wait_rec_nxt;
  logic drv_r, drv_nxt;
  logic rx_r, rx_nxt;
  logic pwr_ok, f_valid, f_data, f_ready;

  function automatic logic pwr_allows(input logic [2:0] p);
    pwr_allows = (p == `CANTMC_PWR_NORMAL) || (p == `CANTMC_PWR_STOP);
  endfunction

  assign pwr_ok = pwr_allows(link.pwr_mode);

  ////////////////////////////////////////////////////////////////////////////
  // Mode selection and enabling.
  always_comb
  begin
    st_nxt = st_r;
    mode_nxt = mode_r;
    cnt_nxt = cnt_r;
    armed_nxt = armed_r;
    fail_nxt = fail_r;
    wait_rec_nxt = wait_rec_r;
    if (link.mode_wr)
    begin
      if (link.mode_req == `CANTMC_MODE_OFF) // RQ2
        mode_nxt = `CANTMC_MODE_OFF;
      else if (link.mode_req == `CANTMC_MODE_WAKE)
        mode_nxt = `CANTMC_MODE_WAKE;
      else if (link.mode_req == `CANTMC_MODE_NORMAL && link.pwr_mode == `CANTMC_PWR_NORMAL) // RQ4 RQ5
        mode_nxt = `CANTMC_MODE_NORMAL;
      else if (link.mode_req == `CANTMC_MODE_RXONLY && pwr_ok) // RQ13
        mode_nxt = `CANTMC_MODE_RXONLY;
      if (mode_nxt != mode_r || mode_nxt != `CANTMC_MODE_WAKE)
        armed_nxt = 1'b1;
    end
    if (!pwr_ok && (mode_nxt == `CANTMC_MODE_NORMAL || mode_nxt == `CANTMC_MODE_RXONLY))
      mode_nxt = `CANTMC_MODE_WAKE; // RQ19
    if (!pwr_ok && link.pwr_mode != `CANTMC_PWR_RESTART)
      armed_nxt = 1'b1;
    if (woke_r && mode_nxt == `CANTMC_MODE_WAKE && mode_r == `CANTMC_MODE_WAKE && pwr_ok)
      armed_nxt = 1'b0; // RQ16
    if (dom_r == 32'(TXD_TO_CYC))
      fail_nxt = 1'b1; // RQ18
    case (st_r)
      CANTMC_ST_OFF:
      begin
        if (mode_nxt == `CANTMC_MODE_NORMAL)
        begin
          st_nxt = CANTMC_ST_EN;
          cnt_nxt = 32'(EN_CYC); // RQ20
        end
        else if (mode_nxt == `CANTMC_MODE_RXONLY)
          st_nxt = CANTMC_ST_RX;
      end
      CANTMC_ST_EN:
      begin
        cnt_nxt = cnt_r - 32'h1; // RQ20
        if (!link.transmit_bit_input)
          wait_rec_nxt = 1'b1; // RQ8
        if (cnt_r <= 32'h1)
        begin
          st_nxt = CANTMC_ST_RUN;
          wait_rec_nxt = wait_rec_r || !link.transmit_bit_input;
        end
      end
      CANTMC_ST_RUN:
      begin
        if (link.transmit_bit_input)
          wait_rec_nxt = 1'b0; // RQ8
        if (dom_r == 32'(TXD_TO_CYC))
          st_nxt = CANTMC_ST_RX; // RQ18
      end
      CANTMC_ST_RX:
      begin
        if (mode_r == `CANTMC_MODE_NORMAL && link.transmit_bit_input)
        begin
          st_nxt = CANTMC_ST_RUN;
          wait_rec_nxt = 1'b0;
        end
      end
      default:
        st_nxt = CANTMC_ST_OFF;
    endcase
    if (mode_nxt != mode_r)
    begin
      st_nxt = CANTMC_ST_OFF;
      wait_rec_nxt = 1'b0;
      if (mode_nxt == `CANTMC_MODE_NORMAL)
      begin
        st_nxt = CANTMC_ST_EN;
        cnt_nxt = 32'(EN_CYC);
      end
      else if (mode_nxt == `CANTMC_MODE_RXONLY)
        st_nxt = CANTMC_ST_RX;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Driver, dominant timeout, receive path and wake detection.
  always_comb
  begin
    drv_nxt = (st_r == CANTMC_ST_RUN) && !wait_rec_r && !link.transmit_bit_input; // RQ8 RQ9 RQ12
    dom_nxt = (st_r == CANTMC_ST_RUN && !link.transmit_bit_input) ?
      ((dom_r == 32'(TXD_TO_CYC)) ? dom_r : dom_r + 32'h1) : 32'h0;
    woke_nxt = woke_r;
    wk_nxt = wk_r;
    if (mode_r != `CANTMC_MODE_WAKE || armed_r && !woke_r)
      woke_nxt = 1'b0;
    if (mode_r == `CANTMC_MODE_WAKE && armed_r && !woke_r) // RQ3 RQ14
    begin
      wk_nxt = bus_rx_dom ? ((wk_r == 16'(WAKE_CYC)) ? wk_r : wk_r + 16'h1) : 16'h0;
      if (wk_r == 16'(WAKE_CYC))
        woke_nxt = 1'b1;
    end
    else
      wk_nxt = 16'h0;
    if (mode_r == `CANTMC_MODE_WAKE && woke_r)
      rx_nxt = 1'b0; // RQ17
    else if (st_r == CANTMC_ST_OFF)
      rx_nxt = 1'b1; // RQ1
    else
      rx_nxt = f_valid ? f_data : rx_r; // RQ10 RQ11
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      st_r <= CANTMC_ST_OFF; // RQ1
      mode_r <= `CANTMC_MODE_OFF;
      cnt_r <= '0;
      dom_r <= '0;
      wk_r <= '0;
      armed_r <= 1'b1;
      woke_r <= 1'b0;
      fail_r <= 1'b0;
      wait_rec_r <= 1'b0;
      drv_r <= 1'b0;
      rx_r <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
      mode_r <= mode_nxt;
      cnt_r <= cnt_nxt;
      dom_r <= dom_nxt;
      wk_r <= wk_nxt;
      armed_r <= armed_nxt;
      woke_r <= woke_nxt;
      fail_r <= fail_nxt;
      wait_rec_r <= wait_rec_nxt;
      drv_r <= drv_nxt;
      rx_r <= rx_nxt;
    end
  end

  // Receiver samples buffered toward the receive output.
  cantmc_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .mclk(mclk),
    .reset(reset),
    .in_data(~bus_rx_dom),
    .in_valid(st_r != CANTMC_ST_OFF),
    .in_ready(f_ready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(1'b1)
  );

  assign link.mode_stat = mode_r; // RQ15 RQ16
  assign link.fail_flag = fail_r;
  assign link.wake_flag = woke_r;
  assign link.rx_out = rx_r;
  assign bus_drive_dom = drv_r;
  assign bus_drv_en = (st_r == CANTMC_ST_RUN);
  assign bus_bias_en = (st_r != CANTMC_ST_OFF) && f_ready;
endmodule
`default_nettype wire

// *** inc/cantmc_regs.svh ***
`ifndef CANTMC_REGS_SVH
`define CANTMC_REGS_SVH
// Transceiver mode field encodings.
`define CANTMC_MODE_OFF 2'h0
`define CANTMC_MODE_WAKE 2'h1
`define CANTMC_MODE_RXONLY 2'h2
`define CANTMC_MODE_NORMAL 2'h3
// Chip power mode encodings.
`define CANTMC_PWR_NORMAL 3'h0
`define CANTMC_PWR_STOP 3'h1
`define CANTMC_PWR_SLEEP 3'h2
`define CANTMC_PWR_RESTART 3'h3
`define CANTMC_PWR_FAILSAFE 3'h4
// Enabling delay in ns and dominant timeout in ns; cycles at 5 ns per clock.
`define CANTMC_CLK_PERIOD_NS 5
`define CANTMC_EN_DELAY_NS 20000
`define CANTMC_EN_DELAY_CYC ((`CANTMC_EN_DELAY_NS + `CANTMC_CLK_PERIOD_NS - 1) / `CANTMC_CLK_PERIOD_NS)
`define CANTMC_TXD_TO_NS 2000000
`define CANTMC_TXD_TO_CYC (`CANTMC_TXD_TO_NS / `CANTMC_CLK_PERIOD_NS)
// Wake filter: dominant bus time needed to count as a wake phase.
`define CANTMC_WAKE_FILT_NS 1000
`define CANTMC_WAKE_FILT_CYC ((`CANTMC_WAKE_FILT_NS + `CANTMC_CLK_PERIOD_NS - 1) / `CANTMC_CLK_PERIOD_NS)
`endif

// *** inc/cantmc_pkg.sv ***
`default_nettype none
package cantmc_pkg;
  typedef logic [1:0] cantmc_mode_t;
  typedef logic [2:0] cantmc_pwr_t;
  typedef enum logic [3:0] {
    CANTMC_ST_OFF = 4'h1,
    CANTMC_ST_EN = 4'h2,
    CANTMC_ST_RUN = 4'h4,
    CANTMC_ST_RX = 4'h8
  } cantmc_state_t;
endpackage
`default_nettype wire

// *** inc/cantmc_if.sv ***
`default_nettype none
interface cantmc_if;
  logic [1:0] mode_req;
  logic mode_wr;
  logic [2:0] pwr_mode;
  logic [1:0] mode_stat;
  logic fail_flag;
  logic wake_flag;
  logic transmit_bit_input;
  logic rx_out;
  modport dev (input mode_req, input mode_wr, input pwr_mode, input transmit_bit_input,
    output mode_stat, output fail_flag, output wake_flag, output rx_out);
  modport host (output mode_req, output mode_wr, output pwr_mode, output transmit_bit_input,
    input mode_stat, input fail_flag, input wake_flag, input rx_out);
endinterface
`default_nettype wire

// *** design/cantmc_fifo.sv ***
`default_nettype none
module cantmc_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 8
) (
  input wire logic mclk, // Clock.
  input wire logic reset, // Synchronous reset.
  input wire logic [WIDTH-1:0] in_data, // Write data.
  input wire logic in_valid, // Write request.
  output logic in_ready, // Not full.
  output logic [WIDTH-1:0] out_data, // Head word.
  output logic out_valid, // Not empty.
  input wire logic out_ready // Head taken.
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    wp_nxt = push ? AW'((wp_r + 1'b1) % DEPTH) : wp_r;
    rp_nxt = pop ? AW'((rp_r + 1'b1) % DEPTH) : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (push)
      mem[wp_r] <= in_data;
  end
endmodule
`default_nettype wire

// *** design/cantmc_host.sv ***
`default_nettype none
`include "cantmc_regs.svh"
module cantmc_host
  import cantmc_pkg::*;
(
  input wire logic mclk, // Clock.
  input wire logic reset, // Synchronous reset.
  cantmc_if.host link, // Transceiver side.
  input wire logic [1:0] user_mode, // Requested transceiver mode.
  input wire logic user_mode_wr, // Mode write strobe.
  input wire logic [2:0] user_pwr, // Chip power mode.
  input wire logic user_tx, // Controller transmit bit, low is dominant.
  output logic user_rx, // Receive level seen.
  output logic user_wake, // Wake flag seen.
  output logic user_fail // Failure flag seen.
);
  logic [15:0] hold_r, hold_nxt;
  logic [1:0] mode_r, mode_nxt;
  logic wr_r, wr_nxt;
  logic rx_r, wake_r, fail_r;

  // Normal requests are only sent in normal power mode; receive-only and other requests are sent in any power mode.
  always_comb
  begin
    mode_nxt = mode_r;
    wr_nxt = 1'b0;
    hold_nxt = (hold_r != '0) ? hold_r - 16'h1 : hold_r;
    if (user_mode_wr)
    begin
      if (user_mode == `CANTMC_MODE_NORMAL && user_pwr != `CANTMC_PWR_NORMAL) // RQ4
        wr_nxt = 1'b0;
      else
      begin
        mode_nxt = user_mode; // RQ15
        wr_nxt = 1'b1;
        if (user_mode == `CANTMC_MODE_NORMAL)
          hold_nxt = 16'(`CANTMC_EN_DELAY_CYC + 1);
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      mode_r <= `CANTMC_MODE_OFF;
      wr_r <= 1'b0;
      hold_r <= '0;
      rx_r <= 1'b1;
      wake_r <= 1'b0;
      fail_r <= 1'b0;
    end
    else
    begin
      mode_r <= mode_nxt;
      wr_r <= wr_nxt;
      hold_r <= hold_nxt;
      rx_r <= link.rx_out;
      wake_r <= link.wake_flag;
      fail_r <= link.fail_flag;
    end
  end

  assign link.mode_req = mode_r;
  assign link.mode_wr = wr_r;
  assign link.pwr_mode = user_pwr;
  assign link.transmit_bit_input = (hold_r != '0) ? 1'b1 : user_tx; // RQ6 RQ7
  assign user_rx = rx_r;
  assign user_wake = wake_r;
  assign user_fail = fail_r;
endmodule
`default_nettype wire

// *** bench/cantmc_asserts.sv ***
`default_nettype none
`include "cantmc_regs.svh"
module cantmc_asserts #(
  parameter int EN_CYC = 10,
  parameter int TXD_TO_CYC = 400
) (
  input wire logic mclk, // Clock.
  input wire logic reset, // Reset.
  input wire logic [1:0] mode_req, // Mode asked.
  input wire logic mode_wr, // Mode write.
  input wire logic [2:0] pwr_mode, // Power mode.
  input wire logic [1:0] mode_stat, // Mode applied.
  input wire logic fail_flag, // Timeout flag.
  input wire logic wake_flag, // Wake flag.
  input wire logic transmit_bit_input, // Transmit bit.
  input wire logic rx_out, // Receive level.
  input wire logic bus_rx_dom, // Bus dominant.
  input wire logic bus_drive_dom, // Driving dominant.
  input wire logic bus_drv_en // Driver on.
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int EN_HI = EN_CYC + 3;
  localparam logic [1:0] M_WAKE = `CANTMC_MODE_WAKE;
  localparam logic [1:0] M_NORM = `CANTMC_MODE_NORMAL;
  int lo_cnt_r;
  int lo_cnt_nxt;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // Counts how long the transmit bit has been held dominant.
  always_comb
  begin
    lo_cnt_nxt = (reset || transmit_bit_input) ? 0 : lo_cnt_r + 1;
  end
  always_ff @(posedge mclk)
  begin
    lo_cnt_r <= lo_cnt_nxt;
  end
  ////////////////////////////////////////
  property p_norm; mode_wr && mode_req == M_NORM && pwr_mode == 3'h0 |=> mode_stat == M_NORM; endproperty
  a_norm: assert property (p_norm) else $error("normal write lost");
  property p_drop; (pwr_mode > 3'h1) [*2] |-> !mode_stat[1]; endproperty
  a_drop: assert property (p_drop) else $error("mode kept in low power");
  property p_en; $rose(mode_stat == M_NORM) && !fail_flag |-> !bus_drv_en [*8] ##[1:EN_HI] bus_drv_en; endproperty
  a_en: assert property (p_en) else $error("enabling delay wrong");
  property p_follow; bus_drv_en && $past(bus_drv_en) |-> bus_drive_dom == !$past(transmit_bit_input); endproperty
  a_follow: assert property (p_follow) else $error("bus not following");
  property p_rxonly; mode_stat == `CANTMC_MODE_RXONLY |-> !bus_drv_en; endproperty
  a_rxonly: assert property (p_rxonly) else $error("driver on in rx only");
  property p_to; $rose(fail_flag) |-> lo_cnt_r >= TXD_TO_CYC - 1; endproperty
  a_to: assert property (p_to) else $error("early timeout");
  property p_wake; $rose(wake_flag) |-> $past(mode_stat) == M_WAKE; endproperty
  a_wake: assert property (p_wake) else $error("wake outside wake mode");
  property p_wake_rx; $rose(wake_flag) |-> ##2 (!rx_out && mode_stat == M_WAKE) [*3]; endproperty
  a_wake_rx: assert property (p_wake_rx) else $error("receive not held low");
  property p_rx; (bus_rx_dom && mode_stat[1]) [*6] |-> !rx_out; endproperty
  a_rx: assert property (p_rx) else $error("receive not following");
  c_drive: cover property (bus_drv_en && bus_drive_dom);
  c_wake: cover property ($rose(wake_flag));
  c_fail: cover property ($rose(fail_flag));
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
`default_nettype none
`include "cantmc_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int EN = 10;
  localparam int TO = 400;
  localparam int WK = 5;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [1:0] user_mode = 2'h0;
  logic user_mode_wr = 1'b0;
  logic [2:0] user_pwr = 3'h0;
  logic user_tx = 1'b1;
  logic bus_rx_dom = 1'b0;
  logic user_rx, user_wake, user_fail, bus_drive_dom, bus_drv_en, bus_bias_en, dom_b, en_b;
  int fail_count = 0;
  int cmp_count = 0;
  cantmc_if link_if ();
  cantmc_if link_b_if ();
  cantmc_host cantmc_host_i (.mclk, .reset, .link(link_if.host), .user_mode, .user_mode_wr, .user_pwr,
    .user_tx, .user_rx, .user_wake, .user_fail);
  cantmc_dev #(.EN_CYC(EN), .TXD_TO_CYC(TO), .WAKE_CYC(WK)) cantmc_dev_i (.mclk, .reset, .link(link_if.dev),
    .bus_rx_dom, .bus_drive_dom, .bus_drv_en, .bus_bias_en);
  // A second end whose controller side the bench drives, so it can misbehave.
  cantmc_dev #(.EN_CYC(EN), .TXD_TO_CYC(TO), .WAKE_CYC(WK)) cantmc_dev_b_i (.mclk, .reset, .link(link_b_if.dev),
    .bus_rx_dom(1'b0), .bus_drive_dom(dom_b), .bus_drv_en(en_b), .bus_bias_en());
  cantmc_asserts #(.EN_CYC(EN), .TXD_TO_CYC(TO)) cantmc_asserts_i (.mclk, .reset, .mode_req(link_if.mode_req),
    .mode_wr(link_if.mode_wr), .pwr_mode(link_if.pwr_mode), .mode_stat(link_if.mode_stat),
    .fail_flag(link_if.fail_flag), .wake_flag(link_if.wake_flag), .rx_out(link_if.rx_out),
    .transmit_bit_input(link_if.transmit_bit_input), .bus_rx_dom, .bus_drive_dom, .bus_drv_en);
  initial
  begin
    forever #2.5 mclk = ~mclk;
  end
  ////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error at %0t ns: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic chk_bit(input logic e, input logic g);
    chk({7'h00, e}, {7'h00, g});
  endtask
  task automatic chk_mode(input logic [1:0] e);
    chk({6'h00, e}, {6'h00, link_if.mode_stat});
  endtask
  task automatic set_mode(input logic [1:0] m);
    user_mode = m;
    user_mode_wr = 1'b1;
    step(1);
    user_mode_wr = 1'b0;
    step(20);
  endtask
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic t_off;
    bus_rx_dom = 1'b1;
    step(WK + 10);
    chk_mode(`CANTMC_MODE_OFF);
    chk_bit(1'b1, user_rx);
    chk_bit(1'b0, bus_drv_en);
    chk_bit(1'b0, user_wake);
    bus_rx_dom = 1'b0;
    $display("test off done");
  endtask
  task automatic t_modes;
    for (int p = 0; p < 5; p++)
    begin
      user_pwr = 3'(p);
      set_mode(`CANTMC_MODE_OFF);
      chk_mode(`CANTMC_MODE_OFF);
      set_mode(`CANTMC_MODE_NORMAL);
      chk_mode(p == 0 ? `CANTMC_MODE_NORMAL : `CANTMC_MODE_OFF);
      set_mode(`CANTMC_MODE_OFF);
      set_mode(`CANTMC_MODE_RXONLY);
      chk_mode(p < 2 ? `CANTMC_MODE_RXONLY : `CANTMC_MODE_OFF);
      set_mode(`CANTMC_MODE_WAKE);
      chk_mode(`CANTMC_MODE_WAKE);
    end
    user_pwr = 3'h0;
    set_mode(`CANTMC_MODE_NORMAL);
    user_pwr = 3'h2;
    step(5);
    chk_mode(`CANTMC_MODE_WAKE);
    chk_bit(1'b0, bus_drv_en);
    user_pwr = 3'h0;
    $display("test modes done");
  endtask
  task automatic t_normal;
    logic [7:0] pat;
    pat = 8'h5a;
    set_mode(`CANTMC_MODE_NORMAL);
    // An early dominant from the controller must not reach the link or the bus.
    user_tx = 1'b0;
    step(5);
    chk_bit(1'b1, link_if.transmit_bit_input);
    chk_bit(1'b0, bus_drive_dom);
    user_tx = 1'b1;
    step(`CANTMC_EN_DELAY_CYC);
    // One bit lasts 100 cycles, the top rate of the stream.
    for (int i = 0; i < 8; i++)
    begin
      user_tx = pat[i];
      bus_rx_dom = ~pat[i];
      step(50);
      chk_bit(~pat[i], bus_drive_dom);
      chk_bit(pat[i], user_rx);
      step(50);
    end
    user_tx = 1'b0;
    step(TO + 10);
    chk_bit(1'b1, user_fail);
    chk_bit(1'b0, bus_drv_en);
    user_tx = 1'b1;
    step(5);
    chk_bit(1'b1, bus_drv_en);
    chk_mode(`CANTMC_MODE_NORMAL);
    $display("test normal done");
  endtask
  task automatic t_rxonly;
    set_mode(`CANTMC_MODE_RXONLY);
    user_tx = 1'b0;
    bus_rx_dom = 1'b1;
    step(10);
    chk_bit(1'b0, bus_drive_dom);
    chk_bit(1'b0, user_rx);
    chk_bit(1'b1, bus_bias_en);
    user_tx = 1'b1;
    bus_rx_dom = 1'b0;
    $display("test rxonly done");
  endtask
  task automatic t_wake;
    set_mode(`CANTMC_MODE_WAKE);
    bus_rx_dom = 1'b1;
    step(WK + 3);
    bus_rx_dom = 1'b0;
    step(10);
    chk_bit(1'b1, user_wake);
    chk_bit(1'b0, user_rx);
    chk_mode(`CANTMC_MODE_WAKE);
    set_mode(`CANTMC_MODE_OFF);
    chk_bit(1'b1, user_rx);
    $display("test wake done");
  endtask
  task automatic t_early;
    link_b_if.mode_req = `CANTMC_MODE_NORMAL;
    link_b_if.transmit_bit_input = 1'b0;
    link_b_if.mode_wr = 1'b1;
    step(1);
    link_b_if.mode_wr = 1'b0;
    step(EN - 1);
    chk_bit(1'b0, en_b);
    step(1);
    chk_bit(1'b1, en_b);
    step(5);
    chk_bit(1'b0, dom_b);
    link_b_if.transmit_bit_input = 1'b1;
    step(3);
    link_b_if.transmit_bit_input = 1'b0;
    step(3);
    chk_bit(1'b1, dom_b);
    link_b_if.transmit_bit_input = 1'b1;
    $display("test early done");
  endtask
  task automatic t_fifo;
    logic [7:0] pat;
    pat = 8'h96;
    set_mode(`CANTMC_MODE_RXONLY);
    // A new bus level every 3 cycles; each must come out of the receive buffer in order.
    for (int i = 0; i < 8; i++)
    begin
      bus_rx_dom = pat[i];
      step(3);
      chk_bit(~pat[i], user_rx);
      chk_bit(1'b1, bus_bias_en);
    end
    bus_rx_dom = 1'b0;
    set_mode(`CANTMC_MODE_OFF);
    chk_bit(1'b1, user_rx);
    chk_mode(`CANTMC_MODE_OFF);
    $display("test fifo done");
  endtask
  ////////////////////////////////////////
  initial
  begin
    link_b_if.mode_req = 2'h0;
    link_b_if.mode_wr = 1'b0;
    link_b_if.pwr_mode = 3'h0;
    link_b_if.transmit_bit_input = 1'b1;
    step(10);
    reset = 1'b0;
    t_off();
    t_modes();
    t_normal();
    t_rxonly();
    t_wake();
    t_early();
    t_fifo();
    stop_test();
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    stop_test();
  end
endmodule
`default_nettype wire
